// ===== rtl/sps_pkg.sv
package sps_pkg;

  // ----------------------------------------------------------------------
  // control register bit positions
  // ----------------------------------------------------------------------
  localparam int CTL_RATE_LOW    = 0;
  localparam int CTL_RATE_HIGH   = 1;
  localparam int CTL_PHASE       = 2;
  localparam int CTL_IDLE_LEVEL  = 3;
  localparam int CTL_MASTER      = 4;
  localparam int CTL_ORDER       = 5;
  localparam int CTL_ENABLE      = 6;
  localparam int CTL_IRQ_ENABLE  = 7;

  // ----------------------------------------------------------------------
  // status register bit positions
  // ----------------------------------------------------------------------
  localparam int STS_DOUBLE      = 0;
  localparam int STS_COLLISION   = 6;
  localparam int STS_DONE        = 7;

  // ----------------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int         BITS       = 8;

  // half period of sck in system clocks per rate index {double,hi,lo}
  // fosc/4,/16,/64,/128,/2,/8,/32,/64
  localparam int HALF_DIV [8] = '{2, 8, 32, 64, 1, 4, 16, 32};

  // least time between slave sck samples: four system clocks
  localparam int SLV_SCK_MIN_DIV = 4;

  typedef enum logic [1:0] {SPS_IDLE, SPS_LEAD, SPS_TRAIL} sps_state_t;

endpackage

// ===== rtl/sps_rate_div.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------------
// half-period enable generator for the master serial clock
// ------------------------------------------------------------------------
module sps_rate_div #(
  parameter int CNT_W = 7
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             run,
  input  wire logic [2:0]       rate_idx,
  // output
  output logic                  half_tick
);

  logic [CNT_W-1:0] cnt_r;
  wire  [CNT_W-1:0] limit = CNT_W'(sps_pkg::HALF_DIV[rate_idx] - 1);
  wire              wrap  = (cnt_r >= limit);

  assign half_tick = run && wrap;

  // restart on every new byte so the first half period is whole
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (!run || wrap)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 1'b1;
  end

endmodule // sps_rate_div

`default_nettype wire

// ===== rtl/sps_port.sv
// Operation
// (R1) master: writing data starts the clock and shifts eight bits out
// (R2) master: after one byte clock stops, done flag sets, irq if enabled
// (R3) software drives slave select in master mode, not this block
// (R4) master pulls select low to start, high after each packet
// (R5) mosi and miso bits exchange simultaneously on each master clock
// (R6) slave with select high: idle, miso released, sck ignored
// (R7) slave data may be loaded while select high, shifts after select low
// (R8) slave: done flag sets after a whole byte, irq if enabled
// (R9) each received byte is copied into the receive buffer
// (R10) transmit single buffered: no write until shift cycle completes
// (R11) receive double buffered: read before next byte completes
// (R12) external master keeps sck at or below fosc/4
// (R13) master forces miso input; slave forces mosi, sck, select input
// (R14) port held inactive while power gate bit is one
// (R15) seven master rates selectable, fastest doubled gives clock/2
// (R16) enable, master, rate low only gives clock/16
// (R17) bit order selects lsb first or msb first
// (R18) done interrupt can wake processor from idle sleep
// (R19) write during transfer sets collision; status read then data clears
// (R20) slave: select high resets logic and drops partial bits
// (R21) master with select input driven low becomes slave, sets done
// (R22) idle level and sample phase give four transfer modes
// (R23) after reset all control bits zero
`timescale 1ns/1ps
`default_nettype none

module sps_port (
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RST_N,
  // processor side
  input  wire logic       CTL_WR,
  input  wire logic [7:0] CTL_WDATA,
  input  wire logic       STS_WR,
  input  wire logic       STS_RD,
  input  wire logic       DATA_WR,
  input  wire logic       DATA_RD,
  input  wire logic [7:0] WDATA,
  input  wire logic       POWER_GATE_BIT,
  input  wire logic       SS_DIR_OUT,
  output logic [7:0]      SERIAL_CONTROL_REG,
  output logic [7:0]      SERIAL_STATUS_REG,
  output logic [7:0]      SERIAL_DATA_REG,
  output logic            XFER_IRQ,
  output logic            WAKE_IDLE,
  // serial pins
  input  wire logic       SCK_I,
  output logic            SCK_O,
  output logic            SCK_OE_OVR,
  input  wire logic       MOSI_I,
  output logic            MOSI_O,
  output logic            MOSI_OE_OVR,
  input  wire logic       MISO_I,
  output logic            MISO_O,
  output logic            MISO_OE_OVR,
  input  wire logic       SS_N_I,
  output logic            SS_IN_FORCED
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0]           ctl_r;
  logic                 dbl_r;
  logic                 done_r;
  logic                 coll_r;
  logic                 armed_r;
  logic [7:0]           shift_r;
  logic [7:0]           rxbuf_r;
  logic [2:0]           cnt_r;
  logic                 sck_r;
  logic                 sck_d_r;
  logic                 ss_d_r;
  logic                 sin_r;
  sps_pkg::sps_state_t  st_r;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire       enabled  = ctl_r[sps_pkg::CTL_ENABLE] && !POWER_GATE_BIT; // [R14]
  wire       master   = enabled && ctl_r[sps_pkg::CTL_MASTER];
  wire       slave    = enabled && !ctl_r[sps_pkg::CTL_MASTER];
  wire       clock_idle_level     = ctl_r[sps_pkg::CTL_IDLE_LEVEL];
  wire       clock_sample_phase     = ctl_r[sps_pkg::CTL_PHASE];
  wire       lsb      = ctl_r[sps_pkg::CTL_ORDER];
  wire [2:0] rate_idx = {dbl_r, ctl_r[sps_pkg::CTL_RATE_HIGH],
                         ctl_r[sps_pkg::CTL_RATE_LOW]}; // [R15] [R16]
  wire       busy     = (st_r != sps_pkg::SPS_IDLE);
  wire       ss_sel   = !SS_N_I;
  // master lost: select input pulled low by another master
  wire       mode_fault = master && !SS_DIR_OUT && ss_sel; // [R21]
  wire       slv_act  = slave && ss_sel; // [R6]
  wire       slv_drop = slave && !ss_sel; // [R20] [R4]
  wire       tx_bit   = lsb ? shift_r[0] : shift_r[7]; // [R17]
  wire [7:0] shl_in   = {shift_r[6:0], sin_r};
  wire [7:0] shr_in   = {sin_r, shift_r[7:1]};
  wire [7:0] shifted  = lsb ? shr_in : shl_in;

  // ----------------------------------------------------------------------
  // master clock divider
  // ----------------------------------------------------------------------
  logic half_tick;
  sps_rate_div #(
    .CNT_W     (7)
  ) u_div (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .run       (master && busy),
    .rate_idx  (rate_idx),
    .half_tick (half_tick)
  );

  // slave sck edges, inputs taken as synchronous
  wire s_rise  = (SCK_I && !sck_d_r);
  wire s_fall  = (!SCK_I && sck_d_r);
  wire s_lead  = slv_act && (clock_idle_level ? s_fall : s_rise); // [R22]
  wire s_trail = slv_act && (clock_idle_level ? s_rise : s_fall);

  // unified leading / trailing edge strobes for both roles
  wire m_lead  = master && half_tick && (st_r == sps_pkg::SPS_LEAD);
  wire m_trail = master && half_tick && (st_r == sps_pkg::SPS_TRAIL);
  wire e_lead  = m_lead  || (s_lead  && busy);
  wire e_trail = m_trail || (s_trail && busy);
  // clock_sample_phase 0 samples leading, clock_sample_phase 1 samples trailing
  wire e_sample = clock_sample_phase ? e_trail : e_lead; // [R22]
  wire e_setup  = clock_sample_phase ? e_lead  : e_trail;
  wire last_bit = (cnt_r == 3'(sps_pkg::BITS - 1));
  wire byte_end = e_trail && last_bit; // [R2] [R8]
  wire rx_in    = master ? MISO_I : MOSI_I; // [R5]

  wire start_m  = master && DATA_WR && !busy && !mode_fault; // [R1]
  wire wr_busy  = DATA_WR && busy; // [R10] [R19]
  // collision and done clear: status read flagged them, then data access
  wire data_acc = DATA_WR || DATA_RD;

  // ----------------------------------------------------------------------
  // control and status
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctl_r <= sps_pkg::CTL_RESET; // [R23]
      dbl_r <= 1'b0;
    end
    else
    begin
      if (CTL_WR)
        ctl_r <= CTL_WDATA;
      else if (mode_fault)
        ctl_r[sps_pkg::CTL_MASTER] <= 1'b0; // [R21]
      if (STS_WR)
        dbl_r <= WDATA[sps_pkg::STS_DOUBLE];
    end
  end

  // clear needs a status read seen with the flag set first
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      done_r  <= 1'b0;
      coll_r  <= 1'b0;
      armed_r <= 1'b0;
    end
    else
    begin
      if (STS_RD && (done_r || coll_r))
        armed_r <= 1'b1;
      else if (data_acc)
        armed_r <= 1'b0;
      // set wins over clear
      if (byte_end || mode_fault)
        done_r <= 1'b1; // [R2] [R8] [R21]
      else if (armed_r && data_acc)
        done_r <= 1'b0; // [R19]
      if (wr_busy)
        coll_r <= 1'b1; // [R19]
      else if (armed_r && data_acc)
        coll_r <= 1'b0; // [R19]
    end
  end

  // ----------------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_r    <= sps_pkg::SPS_IDLE;
      shift_r <= sps_pkg::DATA_RESET;
      rxbuf_r <= sps_pkg::DATA_RESET;
      cnt_r   <= 3'h0;
      sin_r   <= 1'b0;
      sck_r   <= 1'b0;
      sck_d_r <= 1'b0;
      ss_d_r  <= 1'b1;
    end
    else
    begin
      sck_d_r <= SCK_I;
      ss_d_r  <= SS_N_I;
      if (!enabled || mode_fault || slv_drop)
      begin
        // drop partial bits, keep a preloaded byte for the next frame
        st_r  <= sps_pkg::SPS_IDLE; // [R6] [R20] [R14]
        cnt_r <= 3'h0;
        sck_r <= clock_idle_level;
        if (DATA_WR && !busy)
          shift_r <= WDATA; // [R7]
      end
      else
      begin
        if (start_m || (slave && DATA_WR && !busy))
          shift_r <= WDATA; // [R1] [R7]
        if (start_m)
          st_r <= sps_pkg::SPS_LEAD; // [R1]
        else if (slv_act && !busy)
          st_r <= sps_pkg::SPS_LEAD; // [R7]
        else if (e_lead)
          st_r <= sps_pkg::SPS_TRAIL;
        else if (e_trail)
          st_r <= (last_bit && master) ? sps_pkg::SPS_IDLE
                                       : sps_pkg::SPS_LEAD; // [R2]
        if (m_lead || m_trail)
          sck_r <= !sck_r; // [R22]
        else if (!busy)
          sck_r <= clock_idle_level;
        if (e_sample)
          sin_r <= rx_in; // [R5]
        if (e_trail)
        begin
          cnt_r <= cnt_r + 3'h1;
          if (!clock_sample_phase)
            shift_r <= shifted;
        end
        if (e_lead && clock_sample_phase && cnt_r != 3'h0)
          shift_r <= {lsb ? shr_in : shl_in}; // [R5]
        if (byte_end)
        begin
          // clock_sample_phase 1 takes the last bit on this trailing edge
          if (clock_sample_phase)
          begin
            rxbuf_r <= lsb ? {rx_in, shift_r[7:1]}
                           : {shift_r[6:0], rx_in}; // [R9] [R11]
            shift_r <= lsb ? {rx_in, shift_r[7:1]}
                           : {shift_r[6:0], rx_in};
          end
          else
            rxbuf_r <= shifted; // [R9] [R11]
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign SERIAL_CONTROL_REG = ctl_r;
  assign SERIAL_STATUS_REG  = {done_r, coll_r, 5'h00, dbl_r};
  assign SERIAL_DATA_REG    = rxbuf_r; // [R9]
  // level request; also serves as idle wake source
  assign XFER_IRQ  = done_r && ctl_r[sps_pkg::CTL_IRQ_ENABLE]; // [R2] [R8]
  assign WAKE_IDLE = XFER_IRQ; // [R18]

  assign SCK_O        = master ? sck_r : clock_idle_level;
  assign MOSI_O       = tx_bit;
  assign MISO_O       = tx_bit;
  // overrides: 1 means direction forced to input; else software decides
  assign MISO_OE_OVR  = master || (slave && !ss_sel); // [R13] [R6]
  assign MOSI_OE_OVR  = slave; // [R13]
  assign SCK_OE_OVR   = slave; // [R13]
  assign SS_IN_FORCED = slave; // [R13]

endmodule // sps_port

`default_nettype wire

// ===== bench/sps_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ---
// port checker
// ---
module sps_port_chk (
  // processor side
  input wire logic       CLOCK,
  input wire logic       RST_N,
  input wire logic       STS_RD,
  input wire logic       DATA_RD,
  input wire logic       POWER_GATE_BIT,
  input wire logic       SS_DIR_OUT,
  input wire logic [7:0] SERIAL_CONTROL_REG,
  input wire logic [7:0] SERIAL_STATUS_REG,
  input wire logic       XFER_IRQ,
  input wire logic       WAKE_IDLE,
  // pins
  input wire logic       SCK_O,
  input wire logic       SCK_OE_OVR,
  input wire logic       MOSI_OE_OVR,
  input wire logic       MISO_OE_OVR,
  input wire logic       SS_N_I,
  input wire logic       SS_IN_FORCED
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire [7:0] ctl = SERIAL_CONTROL_REG;
  wire       done = SERIAL_STATUS_REG[7];
  wire       coll = SERIAL_STATUS_REG[6];
  wire       mst = ctl[6] && ctl[4] && !POWER_GATE_BIT;
  wire       slv = ctl[6] && !ctl[4] && !POWER_GATE_BIT;
  // status read arms the clear, a later data access fires it
  sequence clear_s;
    STS_RD && (done || coll) ##2 DATA_RD;
  endsequence
  a_irq_follows_done:
    assert property (XFER_IRQ == (done && ctl[7]))
    else $error("irq differs from flag and enable");
  a_wake_follows_irq: assert property (WAKE_IDLE == XFER_IRQ)
    else $error("wake differs from irq");
  a_gate_holds_still:
    assert property (POWER_GATE_BIT && $past(POWER_GATE_BIT)
      |-> $stable(SCK_O) && !$rose(done)) else $error("gated port active");
  a_master_pin_dirs:
    assert property (mst |-> MISO_OE_OVR && !MOSI_OE_OVR && !SCK_OE_OVR)
    else $error("master overrides wrong");
  a_slave_pin_dirs:
    assert property (slv |-> MOSI_OE_OVR && SCK_OE_OVR && SS_IN_FORCED)
    else $error("slave overrides wrong");
  a_slave_miso_off:
    assert property ((slv && SS_N_I) [*3] |-> MISO_OE_OVR)
    else $error("miso not released");
  a_sck_idle_at_end:
    assert property ($rose(done) && ctl[4] |-> SCK_O == ctl[3])
    else $error("sck not idle at byte end");
  a_fault_to_slave:
    assert property (mst && !SS_DIR_OUT && !SS_N_I
      |-> ##[1:5] !ctl[4] && done) else $error("no mode fault");
  a_flags_clear: assert property (clear_s |=> !done && !coll)
    else $error("flags not cleared");
endmodule // sps_port_chk

bind sps_port sps_port_chk u_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .STS_RD(STS_RD), .DATA_RD(DATA_RD),
  .POWER_GATE_BIT(POWER_GATE_BIT), .SS_DIR_OUT(SS_DIR_OUT),
  .SERIAL_CONTROL_REG(SERIAL_CONTROL_REG),
  .SERIAL_STATUS_REG(SERIAL_STATUS_REG), .XFER_IRQ(XFER_IRQ),
  .WAKE_IDLE(WAKE_IDLE), .SCK_O(SCK_O), .SCK_OE_OVR(SCK_OE_OVR),
  .MOSI_OE_OVR(MOSI_OE_OVR), .MISO_OE_OVR(MISO_OE_OVR),
  .SS_N_I(SS_N_I), .SS_IN_FORCED(SS_IN_FORCED)
);
`default_nettype wire

// ===== bench/sps_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ---
// mode 0, msb first peripheral
// ---
module sps_peer (
  // pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  output logic            miso,
  // bench side
  input  wire logic [7:0] tx,
  output logic [7:0]      rx
);
  logic [7:0] sr = 8'h00;
  initial rx = 8'h00;
  always @(negedge ss_n) sr = tx;
  always @(posedge sck) if (!ss_n) rx = {rx[6:0], mosi};
  always @(negedge sck) if (!ss_n) sr = {sr[6:0], ~sr[7]};
  // deselected line shows the inverse so a stale bit cannot pass
  assign miso = ss_n ? ~sr[7] : sr[7];
endmodule // sps_peer
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ---
  // signals
  // ---
  logic       clk, rst_n, gate, ss_out, ss_in, sck_m, mosi_m, p_ss_n;
  logic       irq, wake, sck_o, mosi_o, miso_i, miso_o, ovr;
  logic [4:0] stb;
  logic [7:0] wd, ctl, sts, dat, p_tx, p_rx, s;
  int         fails = 0, checked = 0, hi;
  int         dv [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
  always #2.5 clk = ~clk;
  sps_port u_sps_port (
    .CLOCK(clk), .RST_N(rst_n), .CTL_WR(stb[4]), .CTL_WDATA(wd),
    .STS_WR(stb[3]), .STS_RD(stb[2]), .DATA_WR(stb[1]), .DATA_RD(stb[0]),
    .WDATA(wd), .POWER_GATE_BIT(gate), .SS_DIR_OUT(ss_out),
    .SERIAL_CONTROL_REG(ctl), .SERIAL_STATUS_REG(sts),
    .SERIAL_DATA_REG(dat), .XFER_IRQ(irq), .WAKE_IDLE(wake),
    .SCK_I(sck_m), .SCK_O(sck_o), .SCK_OE_OVR(), .MOSI_I(mosi_m),
    .MOSI_O(mosi_o), .MOSI_OE_OVR(), .MISO_I(miso_i), .MISO_O(miso_o),
    .MISO_OE_OVR(ovr), .SS_N_I(ss_in), .SS_IN_FORCED()
  );
  sps_peer u_sps_peer (
    .sck(sck_o), .mosi(mosi_o), .ss_n(p_ss_n), .miso(miso_i),
    .tx(p_tx), .rx(p_rx)
  );
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // strobes are {ctl wr, sts wr, sts rd, data wr, data rd}
  task automatic put(input logic [4:0] k, input logic [7:0] d);
    @(posedge clk);
    stb <= k;
    wd <= d;
    @(posedge clk);
    stb <= 5'h00;
  endtask
  task automatic clr;
    put(5'h04, 8'h00);
    put(5'h01, 8'h00);
  endtask
  task automatic mbyte(input logic [7:0] c, m, p, input logic col);
    int n;
    put(5'h10, c);
    p_tx <= p;
    p_ss_n <= 1'b0;
    put(5'h02, m);
    if (col)
      put(5'h02, 8'hff);
    hi = 0;
    for (n = 0; n < 3000 && sts[7] !== 1'b1; n++)
    begin
      @(posedge clk);
      hi += (sck_o === 1'b1);
    end
    p_ss_n <= 1'b1;
  endtask
  // bench as master; four clocks a half period keeps within the slave rate
  task automatic sbits(input logic [7:0] m, input int nb);
    s = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      mosi_m <= m[i];
      repeat (4) @(posedge clk);
      sck_m <= 1'b1;
      s = {s[6:0], miso_o};
      repeat (4) @(posedge clk);
      sck_m <= 1'b0;
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  initial
  begin
    clk = 1'b0;
    {rst_n, gate, stb, wd, p_tx, sck_m, mosi_m} = '0;
    {ss_out, ss_in, p_ss_n} = 3'b111;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(ctl, 8'h00);
    check(sts, 8'h00);
    check(dat, 8'h00);
    $display("test reset end");
    put(5'h10, 8'hd1);
    gate <= 1'b1;
    put(5'h02, 8'h11);
    repeat (40) @(posedge clk);
    check(sts, 8'h00);
    gate <= 1'b0;
    $display("test gate end");
    mbyte(8'hd1, 8'ha5, 8'h3c, 1'b1);
    check(8'(hi / 4), 8'd16);
    check(p_rx, 8'ha5);
    check(dat, 8'h3c);
    check(sts, 8'hc0);
    check({6'h00, wake, irq}, 8'h03);
    clr();
    // flags clear on the edge that takes the data read; let it settle
    @(posedge clk);
    check(sts, 8'h00);
    mbyte(8'hf1, 8'h1e, 8'h12, 1'b0);
    check(p_rx, 8'h78);
    check(dat, 8'h48);
    clr();
    $display("test master end");
    for (int r = 0; r < 8; r++)
    begin
      put(5'h08, {7'h00, r[2]});
      mbyte({6'h14, r[1:0]}, 8'h00, 8'h00, 1'b0);
      check(8'(hi / 4), 8'(dv[r]));
      clr();
    end
    put(5'h08, 8'h00);
    put(5'h10, 8'h58);
    repeat (2) @(posedge clk);
    check({7'h00, sck_o}, 8'h01);
    $display("test rates end");
    put(5'h10, 8'h50);
    ss_out <= 1'b0;
    ss_in <= 1'b0;
    repeat (6) @(posedge clk);
    check(ctl, 8'h40);
    check(sts, 8'h80);
    {ss_out, ss_in} <= 2'b11;
    clr();
    $display("test fault end");
    put(5'h10, 8'h40);
    sbits(8'hff, 8);
    check(sts, 8'h00);
    check({7'h00, ovr}, 8'h01);
    ss_in <= 1'b0;
    repeat (8) @(posedge clk);
    sbits(8'hff, 3);
    ss_in <= 1'b1;
    put(5'h02, 8'h5a);
    repeat (8) @(posedge clk);
    ss_in <= 1'b0;
    repeat (8) @(posedge clk);
    sbits(8'hc3, 8);
    repeat (8) @(posedge clk);
    check(s, 8'h5a);
    check(dat, 8'hc3);
    check(sts, 8'h80);
    ss_in <= 1'b1;
    $display("test slave end");
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
